// File: hdl/uef_defines.svh
`ifndef UEF_DEFINES_SVH
`define UEF_DEFINES_SVH

// ------------------------------------------------------------
// Register map (byte addresses)
// ------------------------------------------------------------
`define UEF_ADDR_W        8
`define UEF_OFF_FLAGS     8'h00
`define UEF_OFF_MASK      8'h04
`define UEF_OFF_SUMMARY   8'h08
`define UEF_OFF_IRQ_STAT  8'h0c
`define UEF_OFF_IRQ_CLR   8'h10
`define UEF_OFF_IRQ_EN    8'h14

// ------------------------------------------------------------
// Fields and reset values
// ------------------------------------------------------------
`define UEF_EP_COUNT      8
`define UEF_FIELD_MSB     7
`define UEF_SUMMARY_BIT   0
`define UEF_IRQ_DONE_BIT  0
`define UEF_IRQ_RXZ_BIT   1
`define UEF_IRQ_W         2
`define UEF_FLAGS_RST     8'h00
`define UEF_MASK_RST      8'h00
`define UEF_IRQ_RST       2'h0
`define UEF_RESP_OKAY     2'h0
`define UEF_RESP_SLVERR   2'h2

`endif

// File: hdl/uef_pkg.sv
package uef_pkg;

  typedef logic [7:0]  uef_ep_vec_type;
  typedef logic [1:0]  uef_irq_vec_type;
  typedef logic [1:0]  uef_resp_type;
  typedef logic [31:0] uef_word_type;

endpackage

// File: hdl/uef_endpoint_irq_flags.sv
// Function
// - Completion on endpoint 1-7 sets its flag; endpoint 0 has no flag.
// - Flag reads 0 until data moved on the endpoint, then 1.
// - Mask bit 0 passes transfer and zero-length flags to outputs; 1 blocks.
// - Masked endpoint still sets its transfer flag but raises no done output.
// - Masked endpoint zero-length flag still sets; no zero-length output.
// - Mask bit 0 only gates the zero-length path.
// - Writing 1 to the summary flag clears all transfer flags.
// - Summary flag sets when any endpoint other than 0 finishes a transfer.
//
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "uef_defines.svh"

module uef_endpoint_irq_flags
  import uef_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  input  wire logic                     ce,
  input  wire uef_ep_vec_type           epDone,
  input  wire uef_ep_vec_type           rxZero,
  output var  logic                     epDoneIrq,
  output var  logic                     rxZeroIrq,
  output var  logic                     irq,
  input  wire logic [`UEF_ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output var  logic                     s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output var  logic                     s_axi_wready,
  output var  uef_resp_type             s_axi_bresp,
  output var  logic                     s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [`UEF_ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output var  logic                     s_axi_arready,
  output var  uef_word_type             s_axi_rdata,
  output var  uef_resp_type             s_axi_rresp,
  output var  logic                     s_axi_rvalid,
  input  wire logic                     s_axi_rready
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  uef_ep_vec_type               flags;
  uef_ep_vec_type               mask;
  logic                         summaryFlag;
  uef_irq_vec_type              irqStatus;
  uef_irq_vec_type              irqEnable;
  uef_ep_vec_type               rxZeroPrev;
  logic [`UEF_ADDR_W-1:0]       awAddr;
  logic [7:0]                   wData;
  logic                         wLowLane;
  uef_ep_vec_type               next_flags;

  // ------------------------------------------------------------
  // Write decode
  // ------------------------------------------------------------
  // Address and data are held until both have arrived, in any order
  wire wrCommit = ce && !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire wrLow    = wrCommit && wLowLane;
  wire wrFlags  = wrLow && (awAddr == `UEF_OFF_FLAGS);
  wire wrMask   = wrLow && (awAddr == `UEF_OFF_MASK);
  wire wrSumClr = wrLow && (awAddr == `UEF_OFF_SUMMARY)
                  && wData[`UEF_SUMMARY_BIT];
  wire wrIrqClr = wrLow && (awAddr == `UEF_OFF_IRQ_CLR);
  wire wrIrqEn  = wrLow && (awAddr == `UEF_OFF_IRQ_EN);
  wire wrMapped = (awAddr == `UEF_OFF_FLAGS) || (awAddr == `UEF_OFF_MASK)
                  || (awAddr == `UEF_OFF_SUMMARY)
                  || (awAddr == `UEF_OFF_IRQ_STAT)
                  || (awAddr == `UEF_OFF_IRQ_CLR)
                  || (awAddr == `UEF_OFF_IRQ_EN);

  // ------------------------------------------------------------
  // Events
  // ------------------------------------------------------------
  wire             anyDone   = |epDone[`UEF_FIELD_MSB:1];
  wire uef_ep_vec_type rxRise = rxZero & ~rxZeroPrev;
  wire uef_irq_vec_type irqEvents = {|rxRise, anyDone};
  // Flag bit 0 never carries a transfer flag
  wire [6:0]       flagBits  = flags[`UEF_FIELD_MSB:1];
  wire             doneLevel = |(flagBits & ~mask[`UEF_FIELD_MSB:1]);
  wire             rxLevel   = |(rxZero & ~mask);

  // ------------------------------------------------------------
  // Per-endpoint transfer flags
  // ------------------------------------------------------------
  assign next_flags[0] = 1'b0;
  genvar ep;
  generate
    for (ep = 1; ep < `UEF_EP_COUNT; ep++) begin : gFlag
      // A completion in the clearing cycle wins over the clear
      wire clrBit = wrSumClr || (wrFlags && wData[ep]);
      assign next_flags[ep] = epDone[ep] || (flags[ep] && !clrBit);
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flags       <= `UEF_FLAGS_RST;
      mask        <= `UEF_MASK_RST;
      summaryFlag <= 1'b0;
      rxZeroPrev  <= `UEF_FLAGS_RST;
    end else if (ce) begin
      flags       <= next_flags;
      rxZeroPrev  <= rxZero;
      summaryFlag <= anyDone || (summaryFlag && !wrSumClr);
      if (wrMask) begin
        mask <= wData;
      end
    end
  end

  // ------------------------------------------------------------
  // Interrupt outputs
  // ------------------------------------------------------------
  // Registered so that every output leaves a flip-flop; costs a cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      epDoneIrq <= 1'b0;
      rxZeroIrq <= 1'b0;
      irqStatus <= `UEF_IRQ_RST;
      irqEnable <= `UEF_IRQ_RST;
      irq       <= 1'b0;
    end else if (ce) begin
      epDoneIrq <= doneLevel;
      rxZeroIrq <= rxLevel;
      irqStatus <= irqEvents
                   | (irqStatus & ~(wrIrqClr ? wData[1:0] : 2'h0));
      if (wrIrqEn) begin
        irqEnable <= wData[1:0];
      end
      irq       <= |(irqStatus & irqEnable);
    end
  end

  // ------------------------------------------------------------
  // Write channels
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `UEF_RESP_OKAY;
      awAddr        <= '0;
      wData         <= 8'h00;
      wLowLane      <= 1'b0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr        <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        // Only the low lane carries fields; 31-8 are ignored
        wData         <= s_axi_wdata[7:0];
        wLowLane      <= s_axi_wstrb[0];
        s_axi_wready  <= 1'b0;
      end
      if (wrCommit) begin
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= wrMapped ? `UEF_RESP_OKAY : `UEF_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Read channel
  // ------------------------------------------------------------
  wire arTake = s_axi_arvalid && s_axi_arready;
  wire rdMapped = (s_axi_araddr == `UEF_OFF_FLAGS)
                  || (s_axi_araddr == `UEF_OFF_MASK)
                  || (s_axi_araddr == `UEF_OFF_SUMMARY)
                  || (s_axi_araddr == `UEF_OFF_IRQ_STAT)
                  || (s_axi_araddr == `UEF_OFF_IRQ_CLR)
                  || (s_axi_araddr == `UEF_OFF_IRQ_EN);
  // Upper and reserved bits read zero
  wire [7:0] rdByte =
      (s_axi_araddr == `UEF_OFF_FLAGS)    ? flags :
      (s_axi_araddr == `UEF_OFF_MASK)     ? mask :
      (s_axi_araddr == `UEF_OFF_SUMMARY)  ? {7'h00, summaryFlag} :
      (s_axi_araddr == `UEF_OFF_IRQ_STAT) ? {6'h00, irqStatus} :
      (s_axi_araddr == `UEF_OFF_IRQ_EN)   ? {6'h00, irqEnable} : 8'h00;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `UEF_RESP_OKAY;
    end else if (ce) begin
      if (arTake) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {24'h000000, rdByte};
        s_axi_rresp   <= rdMapped ? `UEF_RESP_OKAY : `UEF_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence seqDoneSeen;
    ce && anyDone;
  endsequence

  sequence seqSummaryClear;
    ce && wrSumClr && !anyDone;
  endsequence

  sequence seqAllMaskedQuiet;
    ce && (doneLevel == 1'b0);
  endsequence

  a_flag_set_on_done: assert property (
    @(posedge clk) disable iff (!rst_b)
    seqDoneSeen |=> ((flagBits & $past(epDone[7:1])) == $past(epDone[7:1])))
    else $error("transfer flag not set after completion");

  a_flag_rises_only: assert property (
    @(posedge clk) disable iff (!rst_b)
    1'b1 |=> ((flagBits & ~$past(flagBits) & ~$past(epDone[7:1])) == 7'h00))
    else $error("transfer flag set without completion");

  a_done_blocked_mask: assert property (
    @(posedge clk) disable iff (!rst_b)
    seqAllMaskedQuiet |=> !epDoneIrq)
    else $error("done output raised with no unmasked flag");

  a_done_level_held: assert property (
    @(posedge clk) disable iff (!rst_b)
    (ce && doneLevel) |=> epDoneIrq)
    else $error("done output low while unmasked flag set");

  a_rx_zero_gate: assert property (
    @(posedge clk) disable iff (!rst_b)
    ce |=> (rxZeroIrq == |($past(rxZero) & ~$past(mask))))
    else $error("zero-length output does not follow mask");

  a_rx_ep0_gate: assert property (
    @(posedge clk) disable iff (!rst_b)
    (ce && rxZero == 8'h01 && !mask[0]) ##1 ce |-> rxZeroIrq)
    else $error("endpoint 0 zero-length flag not passed");

  a_summary_sets: assert property (
    @(posedge clk) disable iff (!rst_b)
    seqDoneSeen |=> summaryFlag)
    else $error("summary flag not set by completion");

  a_summary_clears_flags: assert property (
    @(posedge clk) disable iff (!rst_b)
    seqSummaryClear |=> (flagBits == 7'h00 && !summaryFlag))
    else $error("summary write did not clear flags");

  a_ep0_no_flag: assert property (
    @(posedge clk) disable iff (!rst_b)
    (ce && epDone[0]) |=> !flags[0])
    else $error("endpoint 0 gained a transfer flag");

  a_bresp_holds: assert property (
    @(posedge clk) disable iff (!rst_b)
    (s_axi_bvalid && !s_axi_bready) |=> $stable(s_axi_bvalid)
                                        && $stable(s_axi_bresp))
    else $error("write response dropped before taken");

  a_rdata_holds: assert property (
    @(posedge clk) disable iff (!rst_b)
    (s_axi_rvalid && !s_axi_rready) |=> $stable(s_axi_rvalid)
                                        && $stable(s_axi_rdata))
    else $error("read data dropped before taken");

  a_mask_takes_write: assert property (
    @(posedge clk) disable iff (!rst_b)
    wrMask |=> (mask == $past(wData)))
    else $error("mask register missed a write");

  a_summary_quiet: assert property (
    @(posedge clk) disable iff (!rst_b)
    (ce && !anyDone && !summaryFlag) |=> !summaryFlag)
    else $error("summary flag set without completion");

  a_irq_follows: assert property (
    @(posedge clk) disable iff (!rst_b)
    ce |=> (irq == |($past(irqStatus) & $past(irqEnable))))
    else $error("interrupt output does not follow status");

endmodule

`default_nettype wire

// File: verif/uef_irq_sink.sv
`timescale 1ns/1ns
`default_nettype none

module uef_irq_sink (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       irq,
  output var  logic [7:0] irqCount
);
  logic irqLast;

  // Counts rising edges, as a processor that takes each interrupt once
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irqLast  <= 1'b0;
      irqCount <= 8'h00;
    end else begin
      irqLast <= irq;
      if (irq && !irqLast) begin
        irqCount <= irqCount + 8'h01;
      end
    end
  end
endmodule

`default_nettype wire

// File: verif/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "uef_defines.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin nFail++; \
  $display("ERROR %s exp %h got %h", nm, e, g); end end

module testbench
  import uef_pkg::*;
();
  // ----------------------------------------
  // Stimulus signals
  // ----------------------------------------
  logic            clk           = 1'b0;
  logic            rst_b         = 1'b0;
  logic            ce            = 1'b1;
  uef_ep_vec_type  epDone        = 8'h00;
  uef_ep_vec_type  rxZero        = 8'h00;
  logic [7:0]      s_axi_awaddr  = 8'h00;
  logic [7:0]      s_axi_araddr  = 8'h00;
  uef_word_type    s_axi_wdata   = 32'h0;
  logic [3:0]      s_axi_wstrb   = 4'hf;
  logic            s_axi_awvalid = 1'b0;
  logic            s_axi_wvalid  = 1'b0;
  logic            s_axi_bready  = 1'b0;
  logic            s_axi_arvalid = 1'b0;
  logic            s_axi_rready  = 1'b0;
  logic            epDoneIrq, rxZeroIrq, irq;
  logic            s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic            s_axi_arready, s_axi_rvalid;
  uef_resp_type    s_axi_bresp, s_axi_rresp;
  uef_word_type    s_axi_rdata;
  logic [7:0]      irqCount;
  int              nFail         = 0;
  int              checked       = 0;

  always #4 clk = ~clk;

  uef_endpoint_irq_flags uef_endpoint_irq_flags_inst (
    .clk, .rst_b, .ce, .epDone, .rxZero, .epDoneIrq, .rxZeroIrq, .irq,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);

  uef_irq_sink uef_irq_sink_inst (.clk, .rst_b, .irq, .irqCount);

  // ----------------------------------------
  // Bus tasks, entered just after a rising edge
  // ----------------------------------------
  task automatic printVerdict();
    $display("checked %0d failed %0d", checked, nFail);
    if (nFail == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic hang(input logic done);
    if (!done) begin
      nFail++;
      $display("ERROR bus handshake exp 1 got 0");
      printVerdict();
    end
  endtask

  // Ready for an answer is raised only once it shows, so the slave
  // must hold its response for a cycle
  task automatic wr(input logic [7:0] a, input uef_word_type d,
                    input uef_resp_type er);
    int   n;
    logic done;
    n = 0;
    done = 1'b0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    while (n < 50 && !done) begin
      @(posedge clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      done = s_axi_bvalid && s_axi_bready;
      if (s_axi_bvalid && !done) s_axi_bready <= 1'b1;
    end
    s_axi_bready <= 1'b0;
    hang(done);
    `CHK("bresp", er, s_axi_bresp)
  endtask

  task automatic rdw(input logic [7:0] a, input uef_word_type ed,
                     input uef_resp_type er);
    int   n;
    logic done;
    n = 0;
    done = 1'b0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    while (n < 50 && !done) begin
      @(posedge clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      done = s_axi_rvalid && s_axi_rready;
      if (s_axi_rvalid && !done) s_axi_rready <= 1'b1;
    end
    s_axi_rready <= 1'b0;
    hang(done);
    `CHK("rdata", ed, s_axi_rdata)
    `CHK("rresp", er, s_axi_rresp)
  endtask

  // Outputs trail the flags by one registered stage, so three edges suffice
  task automatic pulse(input uef_ep_vec_type v);
    epDone <= v;
    @(posedge clk);
    epDone <= 8'h00;
    repeat (3) @(posedge clk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic sReset();
    `CHK("epDoneIrq", 1'b0, epDoneIrq)
    rdw(`UEF_OFF_FLAGS, 32'h0, `UEF_RESP_OKAY);
    rdw(`UEF_OFF_MASK, 32'h0, `UEF_RESP_OKAY);
    rdw(`UEF_OFF_IRQ_EN, 32'h0, `UEF_RESP_OKAY);
  endtask

  task automatic sFlags();
    pulse(8'hff);
    rdw(`UEF_OFF_FLAGS, 32'hfe, `UEF_RESP_OKAY);
    `CHK("epDoneIrq", 1'b1, epDoneIrq)
    rdw(`UEF_OFF_SUMMARY, 32'h1, `UEF_RESP_OKAY);
    wr(`UEF_OFF_SUMMARY, 32'h1, `UEF_RESP_OKAY);
    rdw(`UEF_OFF_FLAGS, 32'h0, `UEF_RESP_OKAY);
    repeat (2) @(posedge clk);
    `CHK("epDoneIrq", 1'b0, epDoneIrq)
  endtask

  task automatic sMask();
    wr(`UEF_OFF_MASK, 32'h6, `UEF_RESP_OKAY);
    rdw(`UEF_OFF_MASK, 32'h6, `UEF_RESP_OKAY);
    pulse(8'h04);
    rdw(`UEF_OFF_FLAGS, 32'h4, `UEF_RESP_OKAY);
    `CHK("epDoneIrq", 1'b0, epDoneIrq)
    pulse(8'h08);
    rdw(`UEF_OFF_FLAGS, 32'hc, `UEF_RESP_OKAY);
    `CHK("epDoneIrq", 1'b1, epDoneIrq)
    wr(`UEF_OFF_SUMMARY, 32'h1, `UEF_RESP_OKAY);
    rxZero <= 8'h02;
    repeat (3) @(posedge clk);
    `CHK("rxZeroIrq", 1'b0, rxZeroIrq)
    rxZero <= 8'h01;
    repeat (3) @(posedge clk);
    `CHK("rxZeroIrq", 1'b1, rxZeroIrq)
    wr(`UEF_OFF_MASK, 32'h1, `UEF_RESP_OKAY);
    pulse(8'h02);
    `CHK("rxZeroIrq", 1'b0, rxZeroIrq)
    `CHK("epDoneIrq", 1'b1, epDoneIrq)
    rxZero <= 8'h00;
  endtask

  task automatic sIrq();
    wr(`UEF_OFF_IRQ_CLR, 32'h3, `UEF_RESP_OKAY);
    wr(`UEF_OFF_IRQ_EN, 32'h1, `UEF_RESP_OKAY);
    repeat (2) @(posedge clk);
    `CHK("irq", 1'b0, irq)
    pulse(8'h80);
    `CHK("irq", 1'b1, irq)
    `CHK("irqCount", 8'h01, irqCount)
    wr(`UEF_OFF_IRQ_CLR, 32'h1, `UEF_RESP_OKAY);
    repeat (2) @(posedge clk);
    `CHK("irq", 1'b0, irq)
    rdw(`UEF_OFF_IRQ_STAT, 32'h0, `UEF_RESP_OKAY);
    rdw(`UEF_OFF_IRQ_CLR, 32'h0, `UEF_RESP_OKAY);
    rxZero <= 8'h10;
    repeat (2) @(posedge clk);
    rxZero <= 8'h00;
    rdw(`UEF_OFF_IRQ_STAT, 32'h2, `UEF_RESP_OKAY);
    `CHK("irq", 1'b0, irq)
    wr(`UEF_OFF_FLAGS, 32'h80, `UEF_RESP_OKAY);
    rdw(`UEF_OFF_FLAGS, 32'h2, `UEF_RESP_OKAY);
    `CHK("epDoneIrq", 1'b1, epDoneIrq)
    wr(`UEF_OFF_FLAGS, 32'h2, `UEF_RESP_OKAY);
    `CHK("epDoneIrq", 1'b0, epDoneIrq)
    rdw(8'h20, 32'h0, `UEF_RESP_SLVERR);
    wr(8'h20, 32'h1, `UEF_RESP_SLVERR);
  endtask

  // Reset in mid-run, a frozen cycle and a write with the low lane off
  task automatic sRestart();
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    `CHK("epDoneIrq", 1'b0, epDoneIrq)
    `CHK("irqCount", 8'h00, irqCount)
    rdw(`UEF_OFF_FLAGS, 32'h0, `UEF_RESP_OKAY);
    rdw(`UEF_OFF_SUMMARY, 32'h0, `UEF_RESP_OKAY);
    ce     <= 1'b0;
    epDone <= 8'h20;
    @(posedge clk);
    epDone <= 8'h00;
    ce     <= 1'b1;
    rdw(`UEF_OFF_FLAGS, 32'h0, `UEF_RESP_OKAY);
    rdw(`UEF_OFF_SUMMARY, 32'h0, `UEF_RESP_OKAY);
    s_axi_wstrb <= 4'he;
    wr(`UEF_OFF_MASK, 32'hff, `UEF_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rdw(`UEF_OFF_MASK, 32'h0, `UEF_RESP_OKAY);
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    sReset();
    sFlags();
    sMask();
    sIrq();
    sRestart();
    printVerdict();
  end
endmodule

`default_nettype wire
